/* rtl/amr_pkg.sv */
// constants shared by the mode register serial block
package amr_pkg;
   // register-select codes carried in the command byte
   localparam logic [2:0] RS_COMM_STATUS = 3'h0;
   localparam logic [2:0] RS_MODE        = 3'h1;
   localparam logic [2:0] RS_DATA        = 3'h3;
   localparam logic [2:0] RS_ID          = 3'h4;
   localparam logic [2:0] RS_GPIO_CTRL   = 3'h5;
   // command byte field positions
   localparam int CMD_WEN_BIT  = 7;
   localparam int CMD_READ_BIT = 6;
   localparam int CMD_RS_HI    = 5;
   localparam int CMD_RS_LO    = 3;
   // mode register reset value and field positions
   localparam logic [23:0] MODE_RESET     = 24'h080060;
   localparam int          OP_MODE_HI     = 23;
   localparam int          OP_MODE_LO     = 21;
   localparam int          STATUS_APPEND  = 20;
   localparam int          CLK_SRC_HI     = 19;
   localparam int          CLK_SRC_LO     = 18;
   localparam int          AVG_HI         = 17;
   localparam int          AVG_LO         = 16;
   localparam int          THIRD_ORDER    = 15;
   localparam int          FIXED_ZERO     = 14;
   localparam int          PARITY_EN      = 13;
   localparam int          CLK_DIV        = 12;
   localparam int          SINGLE_CYCLE   = 11;
   localparam int          NOTCH_SIXTY    = 10;
   localparam int          RATE_MSB       = 9;
   localparam int          RATE_LSB       = 0;
   // clock source encodings
   localparam logic [1:0] CLK_SRC_XTAL    = 2'h0;
   localparam logic [1:0] CLK_SRC_EXT     = 2'h1;
   localparam logic [1:0] CLK_SRC_INT     = 2'h2;
   localparam logic [1:0] CLK_SRC_INT_OUT = 2'h3;
   // transfer lengths in bits
   localparam logic [5:0] CMD_BITS    = 6'h08;
   localparam logic [5:0] SHORT_BITS  = 6'h08;
   localparam logic [5:0] WORD_BITS   = 6'h18;
   localparam logic [5:0] DATA_STA    = 6'h20;
   // reset values of the sampled pins (idle high lines)
   localparam logic [2:0] PIN_IDLE = 3'h7;
endpackage : amr_pkg

/* rtl/amr_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module amr_pin_sync #(
   parameter int               WIDTH = 3,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
   logic [WIDTH-1:0] lvl_next;

   // ========================================
   // filter: a change counts once stage two and three agree
   // s1 is read only by s2, so metastability stays contained
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_comb begin
            lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (reset) begin
         s1_reg  <= INIT;
         s2_reg  <= INIT;
         s3_reg  <= INIT;
         lvl_reg <= INIT;
      end else begin
         s1_reg  <= pin;
         s2_reg  <= s1_reg;
         s3_reg  <= s2_reg;
         lvl_reg <= lvl_next;
      end
   end

   assign level = lvl_reg;
endmodule : amr_pin_sync

/* rtl/amr_mode_serial.sv */
// serial port, command decode and mode register of the converter
`timescale 1ns/1ps
// Functional notes
// - mode register sits at select code 001 and resets to 0x080060.
// - mode register is 24 bits, readable and writable serially.
// - transfers carry bit 23 first down to bit 0 last.
// - mode write restarts modulator and filter and sets not-ready.
// - bits 23..21 are the operating mode select, reset 000.
// - with status append set, data reads carry the status byte after.
// - bits 19..18 choose clock source; reset picks internal, pin tristated.
// - remaining fields at fixed positions; bit 14 always zero.
// - clock source 00 crystal, 01 external, 10 internal, 11 internal driven out.
// - not-ready clears on new result, sets after that result is read.
module amr_mode_serial (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        sclk,
   input  wire logic        din,
   input  wire logic        cs_n,
   input  wire logic        conv_valid,
   input  wire logic [23:0] conv_data,
   input  wire logic        conv_err,
   input  wire logic        noref,
   input  wire logic [3:0]  chan_id,
   output logic             dout,
   output logic [23:0]      mode_word,
   output logic             not_ready,
   output logic             filter_restart,
   output logic             clock_pin_b_oe,
   output logic             clk_internal_sel,
   output logic             clk_xtal_sel
);
   typedef enum logic [1:0] {
      AMR_CMD   = 2'b00,
      AMR_WRITE = 2'b01,
      AMR_READ  = 2'b10
   } amr_state_t;

   // ========================================
   // pin synchronisers
   logic [2:0] pins_lvl;
   amr_pin_sync #(.WIDTH(3), .INIT(amr_pkg::PIN_IDLE)) u_sync (
      .mclk  (mclk),
      .reset (reset),
      .pin   ({sclk, din, cs_n}),
      .level (pins_lvl)
   );
   logic sclk_lvl, din_lvl, cs_n_lvl;
   assign sclk_lvl = pins_lvl[2];
   assign din_lvl  = pins_lvl[1];
   assign cs_n_lvl = pins_lvl[0];

   // ========================================
   // state
   amr_state_t  state_reg, state_next;
   logic        sclk_prev_reg, sclk_prev_next;
   logic [5:0]  cnt_reg, cnt_next;
   logic [5:0]  len_reg, len_next;
   logic [2:0]  rs_reg, rs_next;
   logic [31:0] sh_reg, sh_next;
   logic [23:0] mode_reg, mode_next;
   logic [23:0] data_reg, data_next;
   logic        dout_reg, dout_next;
   logic        rdy_n_reg, rdy_n_next;
   logic        restart_reg, restart_next;
   logic        pin_oe_reg, pin_oe_next;
   logic        int_sel_reg, int_sel_next;
   logic        xtal_sel_reg, xtal_sel_next;
   logic        commit;

   logic       rise, fall;
   logic [7:0] cmd_byte, status_byte;
   logic [5:0] cnt_inc;
   assign rise     = sclk_lvl & ~sclk_prev_reg;
   assign fall     = ~sclk_lvl & sclk_prev_reg;
   assign cnt_inc  = cnt_reg + 6'h01;
   assign cmd_byte = {sh_reg[6:0], din_lvl};
   // parity only reported when enabled in the mode word
   assign status_byte = {rdy_n_reg, conv_err, noref,
                         mode_reg[amr_pkg::PARITY_EN] & (^data_reg), chan_id};

   // ========================================
   // next-state: serial engine, mode register, ready flag
   always_comb begin
      state_next     = state_reg;
      sclk_prev_next = sclk_lvl;
      cnt_next       = cnt_reg;
      len_next       = len_reg;
      rs_next        = rs_reg;
      sh_next        = sh_reg;
      mode_next      = mode_reg;
      data_next      = data_reg;
      dout_next      = dout_reg;
      rdy_n_next     = rdy_n_reg;
      restart_next   = 1'b0;
      commit         = 1'b0;
      if (conv_valid) begin
         data_next  = conv_data;
         rdy_n_next = 1'b0;
      end
      if (cs_n_lvl) begin
         // deselect abandons any partial transfer, leaving mode intact
         state_next = AMR_CMD;
         cnt_next   = '0;
      end else begin
         unique case (state_reg)
            AMR_CMD: begin
               if (rise) begin
                  sh_next  = {sh_reg[30:0], din_lvl};
                  cnt_next = cnt_inc;
                  if (cnt_inc == amr_pkg::CMD_BITS) begin
                     cnt_next = '0;
                     rs_next  = cmd_byte[amr_pkg::CMD_RS_HI:amr_pkg::CMD_RS_LO];
                     if (cmd_byte[amr_pkg::CMD_WEN_BIT]) begin
                        state_next = AMR_CMD;  // not a command, keep waiting
                     end else if (cmd_byte[amr_pkg::CMD_READ_BIT]) begin
                        state_next = AMR_READ;
                        unique case (rs_next)
                           amr_pkg::RS_COMM_STATUS: begin
                              len_next = amr_pkg::SHORT_BITS;
                              sh_next  = {status_byte, 24'h000000};
                           end
                           amr_pkg::RS_MODE: begin
                              len_next = amr_pkg::WORD_BITS;
                              sh_next  = {mode_reg, 8'h00};
                           end
                           amr_pkg::RS_DATA: begin
                              // status byte trails the word when appended
                              len_next = mode_reg[amr_pkg::STATUS_APPEND] ?
                                         amr_pkg::DATA_STA : amr_pkg::WORD_BITS;
                              sh_next  = {data_reg, status_byte};
                           end
                           amr_pkg::RS_ID, amr_pkg::RS_GPIO_CTRL: begin
                              len_next = amr_pkg::SHORT_BITS;
                              sh_next  = 32'h00000000;
                           end
                           default: begin
                              len_next = amr_pkg::WORD_BITS;
                              sh_next  = 32'h00000000;
                           end
                        endcase
                     end else if (rs_next != amr_pkg::RS_COMM_STATUS) begin
                        state_next = AMR_WRITE;
                        len_next   = (rs_next == amr_pkg::RS_ID ||
                                      rs_next == amr_pkg::RS_GPIO_CTRL) ?
                                     amr_pkg::SHORT_BITS : amr_pkg::WORD_BITS;
                     end
                  end
               end
            end
            AMR_WRITE: begin
               if (rise) begin
                  sh_next  = {sh_reg[30:0], din_lvl};
                  cnt_next = cnt_inc;
                  if (cnt_inc == len_reg) begin
                     state_next = AMR_CMD;
                     cnt_next   = '0;
                     if (rs_reg == amr_pkg::RS_MODE) begin
                        commit    = 1'b1;
                        mode_next = {sh_reg[22:0], din_lvl};
                        mode_next[amr_pkg::FIXED_ZERO] = 1'b0;
                        restart_next = 1'b1;
                        rdy_n_next   = 1'b1;
                     end
                  end
               end
            end
            AMR_READ: begin
               // drive on falling edge so host samples stable on rising
               if (fall) begin
                  dout_next = sh_reg[31];
                  sh_next   = {sh_reg[30:0], 1'b0};
               end
               if (rise) begin
                  cnt_next = cnt_inc;
                  if (cnt_inc == len_reg) begin
                     state_next = AMR_CMD;
                     cnt_next   = '0;
                     // fresh result arriving now wins, so it is not hidden
                     if (rs_reg == amr_pkg::RS_DATA && !conv_valid) begin
                        rdy_n_next = 1'b1;
                     end
                  end
               end
            end
         endcase
      end
   end

   // ========================================
   // clock source decode, registered from the next mode word
   always_comb begin
      logic [1:0] src;
      src           = mode_next[amr_pkg::CLK_SRC_HI:amr_pkg::CLK_SRC_LO];
      pin_oe_next   = (src == amr_pkg::CLK_SRC_INT_OUT);
      int_sel_next  = (src == amr_pkg::CLK_SRC_INT) ||
                      (src == amr_pkg::CLK_SRC_INT_OUT);
      xtal_sel_next = (src == amr_pkg::CLK_SRC_XTAL);
   end

   // ========================================
   // registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg     <= AMR_CMD;
         sclk_prev_reg <= 1'b1;
         cnt_reg       <= '0;
         len_reg       <= amr_pkg::CMD_BITS;
         rs_reg        <= amr_pkg::RS_COMM_STATUS;
         sh_reg        <= '0;
         mode_reg      <= amr_pkg::MODE_RESET;
         data_reg      <= '0;
         dout_reg      <= 1'b1;
         rdy_n_reg     <= 1'b1;
         restart_reg   <= 1'b0;
         pin_oe_reg    <= 1'b0;
         int_sel_reg   <= 1'b1;
         xtal_sel_reg  <= 1'b0;
      end else begin
         state_reg     <= state_next;
         sclk_prev_reg <= sclk_prev_next;
         cnt_reg       <= cnt_next;
         len_reg       <= len_next;
         rs_reg        <= rs_next;
         sh_reg        <= sh_next;
         mode_reg      <= mode_next;
         data_reg      <= data_next;
         dout_reg      <= dout_next;
         rdy_n_reg     <= rdy_n_next;
         restart_reg   <= restart_next;
         pin_oe_reg    <= pin_oe_next;
         int_sel_reg   <= int_sel_next;
         xtal_sel_reg  <= xtal_sel_next;
      end
   end

   assign dout             = dout_reg;
   assign mode_word        = mode_reg;
   assign not_ready        = rdy_n_reg;
   assign filter_restart   = restart_reg;
   assign clock_pin_b_oe   = pin_oe_reg;
   assign clk_internal_sel = int_sel_reg;
   assign clk_xtal_sel     = xtal_sel_reg;

   // ========================================
   // assertions
   property p_reset_value;
      @(posedge mclk) reset |=> (mode_reg == 24'h080060) && !pin_oe_reg && int_sel_reg;
   endproperty
   a_reset_value: assert property (p_reset_value) else $error("mode reset value wrong");

   property p_commit_word;
      @(posedge mclk) disable iff (reset)
         commit |=> (mode_reg == ($past(mode_next) & 24'hFFBFFF)) && restart_reg && rdy_n_reg;
   endproperty
   a_commit_word: assert property (p_commit_word) else $error("mode write not applied");

   property p_only_on_commit;
      @(posedge mclk) disable iff (reset) !commit |=> $stable(mode_reg);
   endproperty
   a_only_on_commit: assert property (p_only_on_commit) else $error("mode changed early");

   property p_restart_pulse;
      @(posedge mclk) disable iff (reset) restart_reg |=> !restart_reg;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart not a pulse");

   property p_clk_decode;
      @(posedge mclk) disable iff (reset)
         ##1 (pin_oe_reg == (mode_reg[19:18] == 2'b11)) &&
             (xtal_sel_reg == (mode_reg[19:18] == 2'b00));
   endproperty
   a_clk_decode: assert property (p_clk_decode) else $error("clock source decode wrong");

   property p_data_len;
      @(posedge mclk) disable iff (reset)
         (state_reg == AMR_CMD && state_next == AMR_READ && rs_next == 3'h3) |=>
            (len_reg == (mode_reg[20] ? 6'h20 : 6'h18));
   endproperty
   a_data_len: assert property (p_data_len) else $error("data read length wrong");

   property p_ready_clear;
      @(posedge mclk) disable iff (reset) (conv_valid && !commit) |=> !rdy_n_reg;
   endproperty
   a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

   property p_msb_out;
      @(posedge mclk) disable iff (reset)
         (state_reg == AMR_READ && fall && !cs_n_lvl) |=> dout_reg == $past(sh_reg[31]);
   endproperty
   a_msb_out: assert property (p_msb_out) else $error("serial out order wrong");

   property p_zero_bit;
      @(posedge mclk) disable iff (reset) !mode_reg[14];
   endproperty
   a_zero_bit: assert property (p_zero_bit) else $error("fixed bit not zero");
endmodule : amr_mode_serial

/* test/amr_host_model.sv */
// host serial controller model for the mode register port
`timescale 1ns/1ps
module amr_host_model (
   input  wire logic mclk,
   input  wire logic dout,
   output logic      sclk,
   output logic      din,
   output logic      cs_n
);
   // ==========================================
   // idle lines
   // ==========================================
   // serial clock parks high and stands still between frames
   initial begin
      sclk = 1'b1;
      din  = 1'b1;
      cs_n = 1'b1;
   end

   // ==========================================
   // one framed transfer
   // ==========================================
   // command byte first, then n payload bits; 8 mclk per level so the
   // three-stage synchroniser always sees each level
   task automatic frame(input logic [7:0] cmd, input int n, input logic [31:0] w,
                        output logic [31:0] r);
      logic [39:0] sh;
      sh = {cmd, w << (32 - n)};  // command leads the payload
      r  = '0;
      @(negedge mclk);
      cs_n = 1'b0;
      repeat (8) @(negedge mclk);
      for (int i = 0; i < n + 8; i++) begin
         sclk = 1'b0;
         din  = sh[39];  // msb first in both directions
         sh   = sh << 1;
         repeat (8) @(negedge mclk);
         if (i >= 8) r = {r[30:0], dout};  // read bit settled before rise
         sclk = 1'b1;
         repeat (8) @(negedge mclk);
      end
      cs_n = 1'b1;
      din  = ~din;  // released line must not keep looking valid
      repeat (8) @(negedge mclk);
   endtask : frame
endmodule : amr_host_model

/* test/adc_mode_register_bench.sv */
// self-checking bench for the mode register serial block
`timescale 1ns/1ps
module adc_mode_register_bench;
   typedef struct packed {
      logic [23:0] wr;
      logic [23:0] exp;
      logic [2:0]  clk;
   } amr_row_t;

   logic        mclk;
   logic        reset;
   logic        sclk, din, cs_n, dout;
   logic        conv_valid, conv_err, noref;
   logic [23:0] conv_data;
   logic [3:0]  chan_id;
   logic [23:0] mode_word;
   logic        not_ready, filter_restart;
   logic        clock_pin_b_oe, clk_internal_sel, clk_xtal_sel;
   logic [31:0] rd;
   int          failures, checks_done, restarts, cycles, n0;
   // clock sources 00,01,10,11; bit 14 written high must read back low
   amr_row_t    rows [4] = '{
      '{24'hE00000, 24'hE00000, 3'b100},
      '{24'h14FFFF, 24'h14BFFF, 3'b000},
      '{24'h080060, 24'h080060, 3'b010},
      '{24'h0C4321, 24'h0C0321, 3'b011}};

   amr_mode_serial amr_mode_serial_i (
      .mclk(mclk), .reset(reset), .sclk(sclk), .din(din), .cs_n(cs_n),
      .conv_valid(conv_valid), .conv_data(conv_data), .conv_err(conv_err),
      .noref(noref), .chan_id(chan_id), .dout(dout), .mode_word(mode_word),
      .not_ready(not_ready), .filter_restart(filter_restart),
      .clock_pin_b_oe(clock_pin_b_oe), .clk_internal_sel(clk_internal_sel),
      .clk_xtal_sel(clk_xtal_sel));

   amr_host_model amr_host_model_i (
      .mclk(mclk), .dout(dout), .sclk(sclk), .din(din), .cs_n(cs_n));

   // ==========================================
   // clock, pulse counter and hang guard
   // ==========================================
   // one clock feeds device and host alike, as a shared-clock setup would
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;
   // runs near 10k cycles; the ceiling leaves ample slack
   always @(posedge mclk) begin
      cycles++;
      if (filter_restart === 1'b1) restarts++;
      if (cycles == 60000) begin
         failures++;
         final_report();
      end
   end

   // ==========================================
   // helpers
   // ==========================================
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one-cycle result strobe, driven off the sampling edge
   task automatic pulse_result(input logic [23:0] d);
      @(negedge mclk);
      conv_data  = d;
      conv_valid = 1'b1;
      @(negedge mclk);
      conv_valid = 1'b0;
   endtask : pulse_result

   task automatic final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // ==========================================
   // main sequence
   // ==========================================
   initial begin
      reset = 1'b1;
      {conv_valid, conv_err, noref, conv_data, chan_id} = '0;
      repeat (10) @(negedge mclk);
      reset = 1'b0;
      repeat (5) @(negedge mclk);
      check("reset mode", {8'h00, mode_word}, 32'h00080060);
      check("reset not_ready", {31'h0, not_ready}, 32'h1);
      check("reset clocks", {29'h0, clk_xtal_sel, clk_internal_sel, clock_pin_b_oe},
            32'h2);
      check("reset dout", {31'h0, dout}, 32'h1);
      amr_host_model_i.frame(8'h48, 24, 32'h0, rd);
      check("reset readback", rd, 32'h00080060);
      $display("test reset done");

      // each write must commit whole, restart once and raise not_ready
      foreach (rows[k]) begin
         pulse_result(24'h0);
         n0 = restarts;
         amr_host_model_i.frame(8'h08, 24, {8'h00, rows[k].wr}, rd);
         check("mode_word", {8'h00, mode_word}, {8'h00, rows[k].exp});
         check("restart pulses", 32'(restarts - n0), 32'h1);
         check("write not_ready", {31'h0, not_ready}, 32'h1);
         check("clock selects", {29'h0, clk_xtal_sel, clk_internal_sel, clock_pin_b_oe},
               {29'h0, rows[k].clk});
         amr_host_model_i.frame(8'h48, 24, 32'h0, rd);
         check("mode readback", rd, {8'h00, rows[k].exp});
      end
      $display("test row table done");

      // data read with status append and parity on, odd data
      amr_host_model_i.frame(8'h08, 24, 32'h00102000, rd);
      {conv_err, noref, chan_id} = {1'b1, 1'b0, 4'h5};
      pulse_result(24'h000007);
      check("fresh not_ready", {31'h0, not_ready}, 32'h0);
      amr_host_model_i.frame(8'h58, 32, 32'h0, rd);
      check("data plus status", rd, 32'h00000755);
      check("read not_ready", {31'h0, not_ready}, 32'h1);
      // append off: read completes after 24 bits
      amr_host_model_i.frame(8'h08, 24, 32'h00080060, rd);
      pulse_result(24'hABCDEF);
      amr_host_model_i.frame(8'h58, 24, 32'h0, rd);
      check("data only", rd, 32'h00ABCDEF);
      check("short read not_ready", {31'h0, not_ready}, 32'h1);
      $display("test data read done");

      // aborted write after 12 bits leaves the register untouched
      n0 = restarts;
      amr_host_model_i.frame(8'h08, 12, 32'h00000FFF, rd);
      check("partial mode", {8'h00, mode_word}, 32'h00080060);
      check("partial restarts", 32'(restarts - n0), 32'h0);
      $display("test abort done");

      // refused traffic: command with top bit set, write and read elsewhere
      n0 = restarts;
      amr_host_model_i.frame(8'h88, 24, 32'h00FFFFFF, rd);
      check("ignored command", {8'h00, mode_word}, 32'h00080060);
      amr_host_model_i.frame(8'h10, 24, 32'h00FFFFFF, rd);
      check("other select", {8'h00, mode_word}, 32'h00080060);
      check("refused restarts", 32'(restarts - n0), 32'h0);
      amr_host_model_i.frame(8'h50, 24, 32'h0, rd);
      check("other readback", rd, 32'h0);
      // status read alone: not_ready set, noref set, parity off, channel
      {conv_err, noref, chan_id} = {1'b0, 1'b1, 4'hA};
      amr_host_model_i.frame(8'h40, 8, 32'h0, rd);
      check("status byte", rd, 32'h000000AA);
      $display("test refused traffic done");

      // mid-run reset after a written mode, a fresh result and a low dout
      amr_host_model_i.frame(8'h08, 24, 32'h000C4321, rd);
      pulse_result(24'h000001);
      check("pre-reset dout", {31'h0, dout}, 32'h0);
      check("pre-reset not_ready", {31'h0, not_ready}, 32'h0);
      reset = 1'b1;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      repeat (5) @(negedge mclk);
      check("rerun mode", {8'h00, mode_word}, 32'h00080060);
      check("rerun clocks", {29'h0, clk_xtal_sel, clk_internal_sel, clock_pin_b_oe},
            32'h2);
      check("rerun dout", {31'h0, dout}, 32'h1);
      check("rerun not_ready", {31'h0, not_ready}, 32'h1);
      amr_host_model_i.frame(8'h48, 24, 32'h0, rd);
      check("rerun readback", rd, 32'h00080060);
      $display("test mid-run reset done");
      final_report();
   end
endmodule : adc_mode_register_bench
